// ===== idw_regs.sv
// Identify words 85..93 as an AXI4-Lite register bank with feature controls.
// Assumes inputs synchronous to clk_i and a hardware-reset level from the host link.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module idw_regs
   import idw_pkg::*;
#(
   parameter int UDMA_MAX = 6                         // Highest supported Ultra DMA mode
) (
   input  wire logic              clk_i,              // 125 MHz clock
   input  wire logic              rstn_i,             // Async reset, active low
   input  wire logic              hw_reset_i,         // Hardware reset in progress
   input  wire idw_rst_sense_type sense_i,            // Levels sensed during hardware reset
   input  wire logic [7:0]        s_axi_awaddr,       // Write address
   input  wire logic              s_axi_awvalid,      // Write address valid
   output logic                   s_axi_awready,      // Write address ready
   input  wire logic [31:0]       s_axi_wdata,        // Write data
   input  wire logic [3:0]        s_axi_wstrb,        // Byte enables
   input  wire logic              s_axi_wvalid,       // Write data valid
   output logic                   s_axi_wready,       // Write data ready
   output logic [1:0]             s_axi_bresp,        // Write response
   output logic                   s_axi_bvalid,       // Write response valid
   input  wire logic              s_axi_bready,       // Write response ready
   input  wire logic [7:0]        s_axi_araddr,       // Read address
   input  wire logic              s_axi_arvalid,      // Read address valid
   output logic                   s_axi_arready,      // Read address ready
   output logic [31:0]            s_axi_rdata,        // Read data
   output logic [1:0]             s_axi_rresp,        // Read response
   output logic                   s_axi_rvalid,       // Read data valid
   input  wire logic              s_axi_rready        // Read data ready
);

   if (UDMA_MAX < 0 || UDMA_MAX > 6) begin : g_bad_udma
      $error("UDMA_MAX must lie in 0..6");
   end

   // Reset synchroniser
   logic [1:0] rst_sync_r;
   logic       rstn;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rstn = rst_sync_r[1];

   // Supported Ultra DMA modes, one bit per mode
   logic [6:0] udma_sup;
   for (genvar n = 0; n < 7; n++) begin : g_udma_sup
      assign udma_sup[n] = (n <= UDMA_MAX);
   end

   // Register state
   logic [15:0] feat_ctrl_r, feat_ctrl_nxt;
   logic        sec_en_r, sec_en_nxt;
   logic [3:0]  udma_sel_r, udma_sel_nxt;
   logic [15:0] erase_r, erase_nxt;
   logic [13:0] rst_res_r, rst_res_nxt;

   // Write channel state
   logic        aw_held_r, aw_held_nxt;
   logic [7:0]  aw_addr_r, aw_addr_nxt;
   logic        w_held_r, w_held_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0]  w_strb_r, w_strb_nxt;
   logic        awready_r, awready_nxt;
   logic        wready_r, wready_nxt;
   logic        bvalid_r, bvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt;

   // Read channel state
   logic        arready_r, arready_nxt;
   logic        rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0]  rresp_r, rresp_nxt;

   // Assembled identify words
   logic [15:0] word_first, word_udma, word_rst;
   logic        do_wr;
   logic [31:0] wr_mask;

   always_comb begin
      word_first = (feat_ctrl_r & FEAT_WR_MASK) | FEAT_FIXED_ONE;
      word_first[SEC_BIT] = sec_en_r;
      word_udma = {9'h000, udma_sup};
      if (udma_sel_r[UDMA_VLD_BIT]) begin
         word_udma[UDMA_SEL_POS + int'(udma_sel_r[2:0])] = 1'b1;
      end
      word_rst = {2'b01, rst_res_r};
   end

   function automatic logic [32:0] rd_mux(input logic [7:0] a, input logic [15:0] f,
                                          input logic [15:0] u, input logic [15:0] r);
      logic [32:0] v;
      v = {1'b0, 32'h0000_0000};
      unique case (a)
         OFS_FEAT_FIRST:  v[15:0] = f;
         OFS_FEAT_SECOND: v[15:0] = SECOND_WORD;
         OFS_FEAT_THIRD:  v[15:0] = THIRD_WORD;
         OFS_UDMA:        v[15:0] = u;
         OFS_ERASE:       v[15:0] = {8'h00, erase_r[7:0]};
         OFS_ENH_ERASE:   v[15:0] = {8'h00, erase_r[15:8]};
         OFS_APM_LEVEL:   v[15:0] = APM_WORD;
         OFS_RST_RESULT:  v[15:0] = r;
         OFS_FEAT_CTRL:   v[15:0] = feat_ctrl_r;
         OFS_SEC_CMD:     v[15:0] = 16'h0000;
         OFS_UDMA_SEL:    v[3:0]  = udma_sel_r;
         OFS_ERASE_TIME:  v[15:0] = erase_r;
         default:         v[32]   = 1'b1;
      endcase
      return v;
   endfunction : rd_mux

   // Write channel and writable controls
   always_comb begin
      aw_held_nxt   = aw_held_r;
      aw_addr_nxt   = aw_addr_r;
      w_held_nxt    = w_held_r;
      w_data_nxt    = w_data_r;
      w_strb_nxt    = w_strb_r;
      bvalid_nxt    = bvalid_r;
      bresp_nxt     = bresp_r;
      feat_ctrl_nxt = feat_ctrl_r;
      sec_en_nxt    = sec_en_r;
      udma_sel_nxt  = udma_sel_r;
      erase_nxt     = erase_r;
      wr_mask       = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
      do_wr         = aw_held_r && w_held_r && !bvalid_r;
      if (s_axi_awvalid && awready_r) begin
         aw_held_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
         w_held_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (do_wr) begin
         aw_held_nxt = 1'b0;
         w_held_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = RESP_OKAY;
         unique case ({aw_addr_r[7:2], 2'b00})
            // Identify words ignore writes; only the controls below and a hardware reset change them
            OFS_FEAT_FIRST, OFS_FEAT_SECOND, OFS_FEAT_THIRD, OFS_UDMA,
            OFS_ERASE, OFS_ENH_ERASE, OFS_APM_LEVEL, OFS_RST_RESULT: ;
            OFS_FEAT_CTRL: begin
               // Unsupported features cannot be turned on
               feat_ctrl_nxt = ((feat_ctrl_r & ~wr_mask[15:0]) | (w_data_r[15:0] & wr_mask[15:0]))
                               & FEAT_WR_MASK;
            end
            OFS_SEC_CMD: begin
               if (w_strb_r[0] && w_data_r[SEC_SET_BIT]) begin
                  sec_en_nxt = 1'b1;
               end else if (w_strb_r[0] && w_data_r[SEC_CLR_BIT]) begin
                  sec_en_nxt = 1'b0;
               end
            end
            OFS_UDMA_SEL: begin
               // A mode above the supported maximum is refused and the old one kept
               if (w_strb_r[0] && int'(w_data_r[2:0]) <= UDMA_MAX) begin
                  udma_sel_nxt = w_data_r[3:0];
               end
            end
            OFS_ERASE_TIME: begin
               erase_nxt = (erase_r & ~wr_mask[15:0]) | (w_data_r[15:0] & wr_mask[15:0]);
            end
            default: bresp_nxt = RESP_SLVERR;
         endcase
      end
      awready_nxt = !aw_held_nxt && !bvalid_nxt;
      wready_nxt  = !w_held_nxt && !bvalid_nxt;
   end

   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         aw_held_r   <= 1'b0;
         aw_addr_r   <= 8'h00;
         w_held_r    <= 1'b0;
         w_data_r    <= 32'h0000_0000;
         w_strb_r    <= 4'h0;
         awready_r   <= 1'b0;
         wready_r    <= 1'b0;
         bvalid_r    <= 1'b0;
         bresp_r     <= RESP_OKAY;
         feat_ctrl_r <= FEAT_CTRL_RST;
         sec_en_r    <= 1'b0;
         udma_sel_r  <= 4'h0;
         erase_r     <= ERASE_TIME_RST[15:0];
      end else begin
         aw_held_r   <= aw_held_nxt;
         aw_addr_r   <= aw_addr_nxt;
         w_held_r    <= w_held_nxt;
         w_data_r    <= w_data_nxt;
         w_strb_r    <= w_strb_nxt;
         awready_r   <= awready_nxt;
         wready_r    <= wready_nxt;
         bvalid_r    <= bvalid_nxt;
         bresp_r     <= bresp_nxt;
         feat_ctrl_r <= feat_ctrl_nxt;
         sec_en_r    <= sec_en_nxt;
         udma_sel_r  <= udma_sel_nxt;
         erase_r     <= erase_nxt;
      end
   end

   // Read channel
   logic [32:0] rd_val;
   always_comb begin
      arready_nxt = arready_r;
      rvalid_nxt  = rvalid_r;
      rdata_nxt   = rdata_r;
      rresp_nxt   = rresp_r;
      rd_val      = rd_mux({s_axi_araddr[7:2], 2'b00}, word_first, word_udma, word_rst);
      if (rvalid_r && s_axi_rready) begin
         rvalid_nxt  = 1'b0;
         arready_nxt = 1'b1;
      end
      if (s_axi_arvalid && arready_r) begin
         arready_nxt = 1'b0;
         rvalid_nxt  = 1'b1;
         rdata_nxt   = rd_val[31:0];
         rresp_nxt   = rd_val[32] ? RESP_SLVERR : RESP_OKAY;
      end
      if (!arready_r && !rvalid_r && !rvalid_nxt) begin
         arready_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0000_0000;
         rresp_r   <= RESP_OKAY;
      end else begin
         arready_r <= arready_nxt;
         rvalid_r  <= rvalid_nxt;
         rdata_r   <= rdata_nxt;
         rresp_r   <= rresp_nxt;
      end
   end

   // Hardware reset result, caught only while the hardware reset runs
   always_comb begin
      rst_res_nxt = rst_res_r;
      if (hw_reset_i) begin
         rst_res_nxt = 14'h0000;
         rst_res_nxt[RST_CABLE_POS] = sense_i.cable_high;
         if (sense_i.is_dev1) begin
            rst_res_nxt[11]   = sense_i.diag_asserted;
            rst_res_nxt[10:9] = sense_i.number_method;
            rst_res_nxt[8]    = 1'b1;
         end else begin
            rst_res_nxt[6]   = sense_i.answers_dev1;
            rst_res_nxt[5]   = sense_i.busy_seen;
            rst_res_nxt[4]   = sense_i.diag_asserted;
            rst_res_nxt[3]   = sense_i.diag_passed;
            rst_res_nxt[2:1] = sense_i.number_method;
            rst_res_nxt[0]   = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn) begin
      if (!rstn) begin
         rst_res_r <= 14'h0000;
      end else begin
         rst_res_r <= rst_res_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   // Checks
   first_fixed_a: assert property (@(posedge clk_i) disable iff (!rstn)
      word_first[10] && (word_first[15] | word_first[11] | word_first[9] | word_first[8]
                         | word_first[7] | word_first[4] | word_first[2]) == 1'b0)
      else $error("first enabled word fixed bits wrong");

   smart_zero_a: assert property (@(posedge clk_i) disable iff (!rstn)
      word_first[0] == 1'b0)
      else $error("SMART enabled bit not zero");

   sec_cause_a: assert property (@(posedge clk_i) disable iff (!rstn)
      $rose(sec_en_r) |-> $past(do_wr) && $past({aw_addr_r[7:2], 2'b00}) == OFS_SEC_CMD
                          && $past(w_data_r[SEC_SET_BIT]))
      else $error("security enabled without set-password");

   feat_write_a: assert property (@(posedge clk_i) disable iff (!rstn)
      do_wr && {aw_addr_r[7:2], 2'b00} == OFS_FEAT_CTRL && w_strb_r[0]
      |=> word_first[6] == $past(w_data_r[6]) && word_first[5] == $past(w_data_r[5]))
      else $error("look-ahead or write cache bit not reported");

   udma_sel_a: assert property (@(posedge clk_i) disable iff (!rstn)
      $onehot0(word_udma[14:8]) && (word_udma[15] | word_udma[7]) == 1'b0)
      else $error("Ultra DMA selection not one-hot");

   rst_hold_a: assert property (@(posedge clk_i) disable iff (!rstn)
      !hw_reset_i |=> $stable(rst_res_r[12:0]))
      else $error("reset result changed outside hardware reset");

   dev_split_a: assert property (@(posedge clk_i) disable iff (!rstn)
      hw_reset_i && !sense_i.is_dev1 |=> rst_res_r[12:8] == 5'h00 && rst_res_r[0])
      else $error("device 0 reset result wrong");

   rd_latency_a: assert property (@(posedge clk_i) disable iff (!rstn)
      s_axi_arvalid && arready_r |=> rvalid_r ##0 !arready_r)
      else $error("read answer not one cycle after address");

   apm_zero_a: assert property (@(posedge clk_i) disable iff (!rstn)
      s_axi_arvalid && arready_r && {s_axi_araddr[7:2], 2'b00} == OFS_APM_LEVEL
      |=> rdata_r == 32'h0000_0000 && rresp_r == RESP_OKAY)
      else $error("power level word not zero");

   dev1_split_a: assert property (@(posedge clk_i) disable iff (!rstn)
      hw_reset_i && sense_i.is_dev1 |=> rst_res_r[8] && rst_res_r[12] == 1'b0 && rst_res_r[7:0] == 8'h00)
      else $error("device 1 reset result wrong");

   cable_sense_a: assert property (@(posedge clk_i) disable iff (!rstn)
      hw_reset_i |=> rst_res_r[RST_CABLE_POS] == $past(sense_i.cable_high))
      else $error("cable level not captured");

   udma_support_a: assert property (@(posedge clk_i) disable iff (!rstn)
      word_udma[0] && (word_udma[6:0] & (word_udma[6:0] + 7'h01)) == 7'h00)
      else $error("Ultra DMA support bits not contiguous");

   sel_range_a: assert property (@(posedge clk_i) disable iff (!rstn)
      int'(udma_sel_r[2:0]) <= UDMA_MAX)
      else $error("selected Ultra DMA mode above supported maximum");

   second_word_a: assert property (@(posedge clk_i) disable iff (!rstn)
      s_axi_arvalid && arready_r && {s_axi_araddr[7:2], 2'b00} == OFS_FEAT_SECOND
      |=> rdata_r == {16'h0000, SECOND_WORD} && rresp_r == RESP_OKAY)
      else $error("second enabled word wrong");

endmodule : idw_regs

// ===== idw_pkg.sv
// Package for the identify-words register bank (words 85..93 of the identify block).
// Assumes an AXI4-Lite master with 32-bit data; every register is one aligned word.
package idw_pkg;

   // Byte addresses
   localparam logic [7:0] OFS_FEAT_FIRST  = 8'h00;
   localparam logic [7:0] OFS_FEAT_SECOND = 8'h04;
   localparam logic [7:0] OFS_FEAT_THIRD  = 8'h08;
   localparam logic [7:0] OFS_UDMA        = 8'h0C;
   localparam logic [7:0] OFS_ERASE       = 8'h10;
   localparam logic [7:0] OFS_ENH_ERASE   = 8'h14;
   localparam logic [7:0] OFS_APM_LEVEL   = 8'h18;
   localparam logic [7:0] OFS_RST_RESULT  = 8'h1C;
   localparam logic [7:0] OFS_FEAT_CTRL   = 8'h20;
   localparam logic [7:0] OFS_SEC_CMD     = 8'h24;
   localparam logic [7:0] OFS_UDMA_SEL    = 8'h28;
   localparam logic [7:0] OFS_ERASE_TIME  = 8'h2C;

   // Features that the supported word marks as available, SMART excluded
   localparam logic [15:0] FEAT_WR_MASK   = 16'h7068;
   localparam logic [15:0] FEAT_CTRL_RST  = 16'h7068;
   localparam logic [15:0] FEAT_FIXED_ONE = 16'h0400;
   localparam int          SEC_BIT        = 1;
   localparam int          SEC_SET_BIT    = 0;
   localparam int          SEC_CLR_BIT    = 1;
   localparam logic [15:0] SECOND_WORD    = 16'h3500;
   localparam logic [15:0] THIRD_WORD     = 16'h4000;
   localparam logic [15:0] APM_WORD       = 16'h0000;
   localparam int          UDMA_SEL_POS   = 8;
   localparam int          UDMA_VLD_BIT   = 3;
   localparam int          RST_VALID_POS  = 14;
   localparam int          RST_CABLE_POS  = 13;
   localparam logic [31:0] ERASE_TIME_RST = 32'h0000_0000;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Levels captured while hardware reset runs
   typedef struct packed {
      logic       cable_high;
      logic       is_dev1;
      logic       diag_asserted;
      logic       busy_seen;
      logic       answers_dev1;
      logic       diag_passed;
      logic [1:0] number_method;
   } idw_rst_sense_type;

endpackage : idw_pkg

// ===== idw_link_model.sv
// Far-side model: runs a hardware reset and presents the levels sensed during it.
// Assumes go_i is a one-cycle request, driven synchronously to clk_i.
`timescale 1ns/1ps
module idw_link_model
   import idw_pkg::*;
#(
   parameter int PULSE = 4                     // Hardware reset length in cycles
) (
   input  wire logic              clk_i,       // Clock
   input  wire logic              rstn_i,      // Reset, active low
   input  wire logic              go_i,        // Start a hardware reset
   input  wire idw_rst_sense_type cfg_i,       // Levels shown during the reset
   output logic                   hw_reset_o,  // Hardware reset in progress
   output idw_rst_sense_type      sense_o      // Sensed levels
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   always_comb begin
      cnt_nxt = cnt_r;
      if (go_i && cnt_r == 8'h00) cnt_nxt = 8'(PULSE);
      else if (cnt_r != 8'h00) cnt_nxt = cnt_r - 8'h01;
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) cnt_r <= 8'h00;
      else cnt_r <= cnt_nxt;
   end
   assign hw_reset_o = (cnt_r != 8'h00);
   // Levels flip outside the reset, so a word that keeps sampling shows it
   assign sense_o = hw_reset_o ? cfg_i : ~cfg_i;
endmodule : idw_link_model

// ===== tb.sv
// Self-checking bench for the identify-word register bank over AXI4-Lite.
// Assumes the link model drives the hardware reset and sensed levels.
`timescale 1ns/1ps
module tb
   import idw_pkg::*;
;
   localparam int UMAX  = 4;
   localparam int PULSE = 4;
   logic clk_i, rstn_i, go, awvalid, wvalid, bready, arvalid, rready, hw_reset;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   idw_rst_sense_type cfg, sense;
   int mismatches = 0;
   int check_count = 0;
   logic [7:0] ofs [8] = '{OFS_FEAT_FIRST, OFS_FEAT_SECOND, OFS_FEAT_THIRD, OFS_UDMA,
                           OFS_ERASE, OFS_ENH_ERASE, OFS_APM_LEVEL, OFS_RST_RESULT};
   logic [31:0] rv [8] = '{32'h7468, 32'h3500, 32'h4000, 32'h001F, 32'h0, 32'h0, 32'h0, 32'h4000};
   int fbit [6] = '{14, 13, 12, 6, 5, 3};
   logic [7:0] evals [4] = '{8'h00, 8'h01, 8'hFE, 8'hFF};
   logic [7:0] cfgs [4] = '{8'hBD, 8'h02, 8'hFF, 8'h42};

   idw_regs #(.UDMA_MAX(UMAX)) uut (
      .clk_i(clk_i), .rstn_i(rstn_i), .hw_reset_i(hw_reset), .sense_i(sense),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   idw_link_model #(.PULSE(PULSE)) link (
      .clk_i(clk_i), .rstn_i(rstn_i), .go_i(go), .cfg_i(cfg), .hw_reset_o(hw_reset), .sense_o(sense));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: data %h expected %h", $time, got, exp);
      end
   endtask : check_word

   task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: response %h expected %h", $time, got, exp);
      end
   endtask : check_resp

   task automatic timed_out;
      mismatches++;
      $display("wrong value at %0t: bus answer never came", $time);
      tally_and_finish();
   endtask : timed_out

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                            input logic [1:0] er);
      int n;
      bit done;
      done = 1'b0;
      @(posedge clk_i);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50 && !done; n++) begin
         @(posedge clk_i);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            check_resp(bresp, er);
            bready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) timed_out();
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      bit done;
      done = 1'b0;
      @(posedge clk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50 && !done; n++) begin
         @(posedge clk_i);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            check_word(rdata, ed);
            check_resp(rresp, er);
            rready <= 1'b0;
            done = 1'b1;
         end
      end
      if (!done) timed_out();
   endtask : axi_read

   task automatic hw_pulse(input idw_rst_sense_type c);
      @(posedge clk_i);
      cfg <= c;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (PULSE + 2) @(posedge clk_i);
   endtask : hw_pulse

   function automatic logic [31:0] exp_rst(input idw_rst_sense_type s);
      logic [15:0] w;
      w = 16'h4000;
      w[13] = s.cable_high;
      if (s.is_dev1) begin
         w[11] = s.diag_asserted;
         w[10:9] = s.number_method;
         w[8] = 1'b1;
      end else begin
         w[6:3] = {s.answers_dev1, s.busy_seen, s.diag_asserted, s.diag_passed};
         w[2:1] = s.number_method;
         w[0] = 1'b1;
      end
      return {16'h0000, w};
   endfunction : exp_rst

   initial begin
      {rstn_i, go, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      cfg = '0;
      repeat (2) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      // Reset contents, then each read-only word shrugs off a full write
      for (int i = 0; i < 8; i++) begin
         axi_read(ofs[i], rv[i], RESP_OKAY);
         axi_write(ofs[i], 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
         axi_read(ofs[i], rv[i], RESP_OKAY);
      end
      foreach (fbit[i]) begin
         axi_write(OFS_FEAT_CTRL, {16'h0000, 16'h0001 << fbit[i]}, 4'hF, RESP_OKAY);
         axi_read(OFS_FEAT_FIRST, {16'h0000, FEAT_FIXED_ONE | (16'h0001 << fbit[i])}, RESP_OKAY);
      end
      axi_write(OFS_FEAT_CTRL, 32'h0000_FFFF, 4'hF, RESP_OKAY);
      axi_read(OFS_FEAT_FIRST, 32'h7468, RESP_OKAY);
      axi_read(OFS_FEAT_CTRL, 32'h7068, RESP_OKAY);
      // Low byte strobe only: look-ahead, caching and power bits drop
      axi_write(OFS_FEAT_CTRL, 32'h0, 4'h1, RESP_OKAY);
      axi_read(OFS_FEAT_FIRST, 32'h7400, RESP_OKAY);
      axi_write(OFS_SEC_CMD, 32'h1, 4'hF, RESP_OKAY);
      axi_read(OFS_FEAT_FIRST, 32'h7402, RESP_OKAY);
      axi_read(OFS_SEC_CMD, 32'h0, RESP_OKAY);
      axi_write(OFS_SEC_CMD, 32'h2, 4'hF, RESP_OKAY);
      axi_read(OFS_FEAT_FIRST, 32'h7400, RESP_OKAY);
      for (int m = 0; m <= UMAX; m++) begin
         axi_write(OFS_UDMA_SEL, 32'h8 | m, 4'hF, RESP_OKAY);
         axi_read(OFS_UDMA, {16'h0000, 16'h001F | (16'h0001 << (8 + m))}, RESP_OKAY);
      end
      // A mode beyond the supported range leaves the selection alone
      axi_write(OFS_UDMA_SEL, 32'h8 | (UMAX + 1), 4'hF, RESP_OKAY);
      axi_read(OFS_UDMA, 32'h101F, RESP_OKAY);
      axi_read(OFS_UDMA_SEL, 32'h8 | UMAX, RESP_OKAY);
      axi_write(OFS_UDMA_SEL, 32'h0, 4'hF, RESP_OKAY);
      axi_read(OFS_UDMA, 32'h001F, RESP_OKAY);
      foreach (evals[i]) begin
         axi_write(OFS_ERASE_TIME, {16'h0000, ~evals[i], evals[i]}, 4'hF, RESP_OKAY);
         axi_read(OFS_ERASE, {24'h0, evals[i]}, RESP_OKAY);
         axi_read(OFS_ENH_ERASE, {24'h0, ~evals[i]}, RESP_OKAY);
         axi_read(OFS_ERASE_TIME, {16'h0000, ~evals[i], evals[i]}, RESP_OKAY);
      end
      axi_write(8'h30, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      axi_read(8'h30, 32'h0, RESP_SLVERR);
      // Both reads see flipped sense levels, the word must not follow them
      foreach (cfgs[i]) begin
         hw_pulse(cfgs[i]);
         axi_read(OFS_RST_RESULT, exp_rst(cfgs[i]), RESP_OKAY);
         axi_read(OFS_RST_RESULT, exp_rst(cfgs[i]), RESP_OKAY);
      end
      tally_and_finish();
   end
endmodule : tb
